/* File: rtl/adcc_pkg.sv */
package adcc_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CONV_CFG   = 8'h00;
   localparam logic [7:0] OFS_TRIG_CMP   = 8'h04;
   localparam logic [7:0] OFS_CHAN_MODE  = 8'h08;
   localparam logic [7:0] OFS_RES_HIGH   = 8'h0c;
   localparam logic [7:0] OFS_RES_LOW    = 8'h10;
   localparam logic [7:0] OFS_CMP_HIGH   = 8'h14;
   localparam logic [7:0] OFS_CMP_LOW    = 8'h18;
   localparam logic [7:0] OFS_PIN_FIRST  = 8'h1c;
   localparam logic [7:0] OFS_PIN_SECOND = 8'h20;

   // ------------------------------------------------------------
   // field codes and widths
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_10BIT   = 2'h2;
   localparam logic [1:0] ICLK_BUS     = 2'h0;
   localparam logic [1:0] ICLK_BUS_DV2 = 2'h1;
   localparam logic [3:0] MSB_10BIT    = 4'h9;
   localparam logic [3:0] MSB_8BIT     = 4'h7;
   localparam logic [9:0] RESET_RES    = 10'h000;
   localparam logic [4:0] RESET_CHAN   = 5'h00;

   // ------------------------------------------------------------
   // timing: sample window in half conversion-clock cycles
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned SMP_SHORT_HALF = 7;
   localparam int unsigned SMP_LONG_HALF  = 47;
   localparam logic [4:0]  SMP_SHORT_CYC  = 5'((SMP_SHORT_HALF + 1) / 2);
   localparam logic [4:0]  SMP_LONG_CYC   = 5'((SMP_LONG_HALF + 1) / 2);
   localparam logic [2:0]  SETTLE_CYC     = 3'h4;

   typedef struct packed {
      logic       low_power_select;
      logic [1:0] clock_divide_field;
      logic       long_sample_select;
      logic [1:0] mode;
      logic [1:0] input_clock_select;
   } adcc_cfg_t;

   typedef struct packed {
      logic       trigger_source_select;
      logic       compare_enable;
      logic       compare_direction;
      logic [1:0] test_bits;
   } adcc_trig_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_SAMPLE  = 3'b010,
      ST_CONVERT = 3'b100
   } adcc_state_t;

endpackage

/* File: rtl/adcc_core.sv */
`timescale 1ns/1ps
// Behaviour
// [R1] config: low power, divide, long sample, mode, source
// [R2] divide 00 passes input clock undivided
// [R3] mode 10 selects 10-bit, else 8-bit
// [R4] source 00 feeds bus clock to divider
// [R5] activity flag high while converting
// [R6] trigger select: 0 software, 1 hardware
// [R7] compare enable and compare direction bits
// [R8] reserved control bits read zero
// [R9] software writes zero to test bits
// [R10] complete flag set when conversion finishes
// [R11] interrupt raised when flag set and enabled
// [R12] mode bit: single or continuous conversions
// [R13] channel field selects input channel
// [R14] high read locks result until low read
// [R15] compare value registers hold threshold
// [R16] pin control bit disables digital pin
// [R17] conversion allowed regardless of pin control
// [R18] saturated codes full scale or zero
// [R19] sample window 3.5 or 23.5 clocks; code samples for 4 or 24 conversion clocks
// [R20] software writes config, trigger, channel order
// [R21] flag set only when compare condition true
// [R22] false compare leaves flag and result alone
// [R23] channel write aborts and restarts conversion
// [R24] low result read clears complete flag
module adcc_core
   import adcc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        ce_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        hw_trig_i,
   input  wire logic        alt_clk_i,
   input  wire logic        sar_cmp_i,
   output logic      [9:0]  sar_dac_o,
   output logic             sample_o,
   output logic      [4:0]  chan_o,
   output logic             low_power_o,
   output logic      [15:0] pin_disable_o,
   output logic             irq_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   adcc_cfg_t   cfg_reg;
   adcc_trig_t  trig_reg;
   adcc_state_t state_reg;
   logic        done_reg;
   logic        ien_reg;
   logic        cont_reg;
   logic [4:0]  chan_reg;
   logic [9:0]  res_reg;
   logic [9:0]  cv_reg;
   logic [15:0] pc_reg;
   logic        lock_reg;
   logic [9:0]  sar_reg;
   logic [3:0]  bit_reg;
   logic [4:0]  smp_reg;
   logic [2:0]  step_reg;
   logic [2:0]  div_reg;
   logic        half_reg;
   logic        trg_s1, trg_s2, trg_s3;
   logic        alt_s1, alt_s2, alt_s3;
   logic        cmp_s1, cmp_s2;
   logic [31:0] rd_data;
   logic        addr_ok;
   logic        in_en;
   logic        cnv_tick;
   logic        hw_rise;
   logic        wr_done;
   logic        rd_done;
   logic        wr_sc1;
   logic        rd_lo;
   logic        rd_hi;
   logic        finish;
   logic        keep_bit;
   logic [9:0]  code;
   logic [9:0]  code_m;
   logic [9:0]  cv_m;
   logic [10:0] diff;
   logic        cond;
   logic        set_conversion_complete_flag;
   logic        store;
   logic [3:0]  msb;
   logic [4:0]  smp_len;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         {trg_s1, trg_s2, trg_s3} <= 3'h0;
         {alt_s1, alt_s2, alt_s3} <= 3'h0;
         {cmp_s1, cmp_s2}         <= 2'h0;
      end else if (ce_i) begin
         trg_s1 <= hw_trig_i;
         trg_s2 <= trg_s1;
         trg_s3 <= trg_s2;
         alt_s1 <= alt_clk_i;
         alt_s2 <= alt_s1;
         alt_s3 <= alt_s2;
         cmp_s1 <= sar_cmp_i;
         cmp_s2 <= cmp_s1;
      end
   end

   assign hw_rise = trg_s2 & ~trg_s3;

   // ------------------------------------------------------------
   // conversion clock divider
   // ------------------------------------------------------------
   always_comb begin
      unique case (cfg_reg.input_clock_select)
         ICLK_BUS:     in_en = 1'b1;   // [R4]
         ICLK_BUS_DV2: in_en = half_reg;
         default:      in_en = alt_s2 & ~alt_s3;
      endcase
   end

   // divide 1,2,4,8; code 00 ticks on every input clock [R2]
   assign cnv_tick = in_en && (div_reg >= 3'((4'h1 << cfg_reg.clock_divide_field) - 4'h1));

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         div_reg  <= 3'h0;
         half_reg <= 1'b0;
      end else if (ce_i) begin
         half_reg <= ~half_reg;
         if (cnv_tick)
            div_reg <= 3'h0;
         else if (in_en)
            div_reg <= div_reg + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign wr_done = psel_i & penable_i & pready_o & pwrite_i;
   assign rd_done = psel_i & penable_i & pready_o & ~pwrite_i;
   assign wr_sc1  = wr_done && paddr_i == OFS_CHAN_MODE;
   assign rd_hi   = rd_done && paddr_i == OFS_RES_HIGH;
   assign rd_lo   = rd_done && paddr_i == OFS_RES_LOW;

   always_comb begin
      rd_data = 32'h0;
      addr_ok = 1'b1;
      unique case (paddr_i)
         OFS_CONV_CFG:   rd_data[7:0] = cfg_reg;
         // reserved bits 3:2 always read zero [R8]
         OFS_TRIG_CMP:   rd_data[7:0] = {state_reg != ST_IDLE, trig_reg.trigger_source_select,
                                         trig_reg.compare_enable, trig_reg.compare_direction,
                                         2'h0, trig_reg.test_bits};   // [R5] [R7]
         OFS_CHAN_MODE:  rd_data[7:0] = {done_reg, ien_reg, cont_reg, chan_reg};
         OFS_RES_HIGH:   rd_data[1:0] = res_reg[9:8];
         OFS_RES_LOW:    rd_data[7:0] = res_reg[7:0];
         OFS_CMP_HIGH:   rd_data[1:0] = cv_reg[9:8];
         OFS_CMP_LOW:    rd_data[7:0] = cv_reg[7:0];
         OFS_PIN_FIRST:  rd_data[7:0] = pc_reg[7:0];
         OFS_PIN_SECOND: rd_data[7:0] = pc_reg[15:8];
         default:        addr_ok      = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0;
      end else if (ce_i) begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= rd_data;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cfg_reg  <= '0;
         trig_reg <= '0;
         ien_reg  <= 1'b0;
         cont_reg <= 1'b0;
         chan_reg <= RESET_CHAN;
         cv_reg   <= RESET_RES;
         pc_reg   <= 16'h0;
      end else if (ce_i && wr_done) begin
         unique case (paddr_i)
            OFS_CONV_CFG:   cfg_reg  <= pwdata_i[7:0];   // [R1] [R3]
            OFS_TRIG_CMP:   trig_reg <= {pwdata_i[6:4], pwdata_i[1:0]};   // [R6] [R7] [R9]
            OFS_CHAN_MODE: begin
               ien_reg  <= pwdata_i[6];
               cont_reg <= pwdata_i[5];   // [R12]
               chan_reg <= pwdata_i[4:0];   // [R13]
            end
            OFS_CMP_HIGH:   cv_reg[9:8]  <= pwdata_i[1:0];   // [R15]
            OFS_CMP_LOW:    cv_reg[7:0]  <= pwdata_i[7:0];   // [R15]
            OFS_PIN_FIRST:  pc_reg[7:0]  <= pwdata_i[7:0];
            OFS_PIN_SECOND: pc_reg[15:8] <= pwdata_i[7:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // successive approximation sequencer
   // ------------------------------------------------------------
   assign msb      = (cfg_reg.mode == MODE_10BIT) ? MSB_10BIT : MSB_8BIT;   // [R3]
   assign smp_len  = cfg_reg.long_sample_select ? SMP_LONG_CYC : SMP_SHORT_CYC;   // [R19]
   assign keep_bit = cmp_s2;
   assign finish   = state_reg == ST_CONVERT && cnv_tick && step_reg >= SETTLE_CYC
                     && bit_reg == 4'h0 && !wr_sc1;   // [R23]

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         sar_reg   <= RESET_RES;
         bit_reg   <= 4'h0;
         smp_reg   <= 5'h0;
         step_reg  <= 3'h0;
      end else if (ce_i) begin
         if (wr_sc1) begin
            // channel write aborts; sw trigger restarts at once [R23]
            state_reg <= !trig_reg.trigger_source_select ? ST_SAMPLE : ST_IDLE;   // [R6]
            smp_reg   <= 5'h0;
         end else begin
            unique case (state_reg)
               ST_IDLE: begin
                  if (trig_reg.trigger_source_select && hw_rise) begin   // [R6]
                     state_reg <= ST_SAMPLE;
                     smp_reg   <= 5'h0;
                  end
               end
               ST_SAMPLE: begin
                  if (cnv_tick) begin
                     smp_reg <= smp_reg + 5'h1;
                     if (smp_reg == smp_len - 5'h1) begin   // [R19]
                        state_reg <= ST_CONVERT;
                        bit_reg   <= msb;
                        sar_reg   <= RESET_RES;
                        step_reg  <= 3'h0;
                     end
                  end
               end
               ST_CONVERT: begin
                  if (step_reg < SETTLE_CYC)
                     step_reg <= step_reg + 3'h1;
                  else if (cnv_tick) begin
                     // comparator high keeps the trial bit, so overrange
                     // saturates at all ones and underrange at zero [R18]
                     sar_reg[bit_reg] <= keep_bit;
                     step_reg         <= 3'h0;
                     if (bit_reg == 4'h0) begin
                        state_reg <= cont_reg ? ST_SAMPLE : ST_IDLE;   // [R12]
                        smp_reg   <= 5'h0;
                     end else
                        bit_reg <= bit_reg - 4'h1;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // result, compare and completion
   // ------------------------------------------------------------
   always_comb begin
      code          = sar_reg;
      code[bit_reg] = keep_bit;
   end

   assign code_m   = (msb == MSB_10BIT) ? code : {2'h0, code[7:0]};
   assign cv_m     = (msb == MSB_10BIT) ? cv_reg : {2'h0, cv_reg[7:0]};
   assign diff     = {1'b0, code_m} - {1'b0, cv_m};
   assign cond     = trig_reg.compare_direction ? ~diff[10] : diff[10];   // [R21]
   assign set_conversion_complete_flag = finish && (!trig_reg.compare_enable || cond);   // [R10] [R21] [R22]
   assign store    = set_conversion_complete_flag && !lock_reg;   // [R14] [R22]

   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         res_reg <= RESET_RES;
      else if (ce_i && store) begin
         if (trig_reg.compare_enable)
            res_reg <= diff[9:0] & ((msb == MSB_10BIT) ? 10'h3ff : 10'h0ff);
         else
            res_reg <= code_m;
      end
   end

   // set wins over a clearing read in the same cycle
   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         done_reg <= 1'b0;
      else if (ce_i) begin
         if (set_conversion_complete_flag)
            done_reg <= 1'b1;   // [R10]
         else if (wr_sc1 || rd_lo)
            done_reg <= 1'b0;   // [R23] [R24]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         lock_reg <= 1'b0;
      else if (ce_i) begin
         if (rd_hi)
            lock_reg <= 1'b1;   // [R14]
         else if (rd_lo)
            lock_reg <= 1'b0;   // [R14]
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sar_dac_o     <= RESET_RES;
         sample_o      <= 1'b0;
         chan_o        <= RESET_CHAN;
         low_power_o   <= 1'b0;
         pin_disable_o <= 16'h0;
         irq_o         <= 1'b0;
      end else if (ce_i) begin
         sar_dac_o     <= sar_reg | (state_reg == ST_CONVERT ? 10'(11'h1 << bit_reg) : 10'h0);
         sample_o      <= state_reg == ST_SAMPLE;
         chan_o        <= chan_reg;   // [R13] [R17]
         low_power_o   <= cfg_reg.low_power_select;
         pin_disable_o <= pc_reg;   // [R16]
         irq_o         <= done_reg & ien_reg;   // [R11]
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   rsv_read_zero_a: assert property ( // [R8]
      ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == OFS_TRIG_CMP
      |=> prdata_o[3:2] == 2'h0)
      else $error("reserved bits read nonzero");

   active_flag_a: assert property ( // [R5]
      ce_i && psel_i && !penable_i && !pwrite_i && paddr_i == OFS_TRIG_CMP
      |=> prdata_o[7] == $past(state_reg != ST_IDLE))
      else $error("activity flag wrong");

   sw_restart_a: assert property ( // [R23]
      ce_i && wr_sc1 && !trig_reg.trigger_source_select
      |=> state_reg == ST_SAMPLE && !done_reg && smp_reg == 5'h0)
      else $error("software start not taken");

   irq_raise_a: assert property ( // [R11]
      ce_i && done_reg && ien_reg |=> irq_o)
      else $error("interrupt not raised");

   lock_hold_a: assert property ( // [R14]
      ce_i && lock_reg && !rd_lo |=> $stable(res_reg))
      else $error("locked result overwritten");

   done_clear_a: assert property ( // [R24]
      ce_i && rd_lo && !set_conversion_complete_flag |=> !done_reg)
      else $error("complete flag not cleared");

   cmp_block_a: assert property ( // [R22]
      ce_i && finish && trig_reg.compare_enable && !cond
      |=> $stable(res_reg) && done_reg == ($past(done_reg) && !$past(rd_lo)))
      else $error("false compare changed state");

   eight_bit_a: assert property ( // [R18]
      ce_i && store && cfg_reg.mode != MODE_10BIT |=> res_reg[9:8] == 2'h0)
      else $error("8-bit result exceeds full scale");

   div_one_a: assert property ( // [R2]
      cfg_reg.clock_divide_field == 2'h0 && cfg_reg.input_clock_select == ICLK_BUS
      |-> cnv_tick)
      else $error("undivided bus clock missing tick");

   sample_len_a: assert property ( // [R19]
      ce_i && state_reg == ST_SAMPLE && cnv_tick && !wr_sc1 && smp_reg == smp_len - 5'h1
      |=> state_reg == ST_CONVERT && bit_reg == $past(msb))
      else $error("sample window length wrong");

endmodule

/* File: dv/adcc_analog_model.sv */
`timescale 1ns/1ps
module adcc_analog_model (
   input  wire logic        clk_i,
   input  wire logic        sample_i,
   input  wire logic        bits10_i,
   input  wire logic [9:0]  dac_i,
   input  wire logic [10:0] level_i,
   output logic             cmp_o
);
   // ------------------------------------------------------------
   // held input level and comparator
   // ------------------------------------------------------------
   logic [10:0] held_reg = 11'h000;

   // level tracked on the sampling cap while sampling, frozen once sampling ends
   always_ff @(posedge clk_i) begin
      if (sample_i) begin
         held_reg <= level_i;
      end
   end

   // level past full scale beats every trial, zero beats none
   always_comb begin
      if (bits10_i) begin
         cmp_o = ({1'b0, dac_i} <= held_reg);
      end else begin
         cmp_o = ({1'b0, dac_i[7:0]} <= held_reg[10:2]);
      end
   end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import adcc_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        hw_trig = 1'b0;
   logic        alt_clk = 1'b0;
   logic [10:0] level = 11'h000;
   logic        bits10 = 1'b1;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sar_cmp;
   logic [9:0]  sar_dac;
   logic        sample;
   logic [4:0]  chan;
   logic        low_power;
   logic [15:0] pin_dis;
   logic        irq;
   logic [31:0] rd;
   int          n_errors = 0;
   int          n_tests = 0;
   int          smp_cnt = 0;

   always #25 clk = ~clk;
   always #170 alt_clk = ~alt_clk;

   always @(posedge clk) begin
      if (sample === 1'b1) begin
         smp_cnt <= smp_cnt + 1;
      end
   end

   adcc_core adcc_core_i (
      .clk_i(clk), .reset_n_i(reset_n), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .hw_trig_i(hw_trig), .alt_clk_i(alt_clk),
      .sar_cmp_i(sar_cmp), .sar_dac_o(sar_dac), .sample_o(sample), .chan_o(chan),
      .low_power_o(low_power), .pin_disable_o(pin_dis), .irq_o(irq)
   );

   adcc_analog_model adcc_analog_model_i (
      .clk_i(clk), .sample_i(sample), .bits10_i(bits10), .dac_i(sar_dac),
      .level_i(level), .cmp_o(sar_cmp)
   );

   // ------------------------------------------------------------
   // report and bus tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         check("pready", 32'h0, 32'h1);
         tally_and_finish();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdreg(input logic [7:0] a);
      logic e;
      apb(1'b0, a, 8'h00, rd, e);
   endtask

   task automatic wait_done();
      int i;
      for (i = 0; i < 300; i++) begin
         rdreg(OFS_CHAN_MODE);
         if (rd[7] === 1'b1) break;
      end
      if (i == 300) begin
         check("done_flag", 32'h0, 32'h1);
         tally_and_finish();
      end
   endtask

   task automatic convert(input logic [7:0] sc1, input logic [10:0] lvl, input logic [9:0] res,
                          input int smp);
      int smp0;
      level <= lvl;
      smp0 = smp_cnt;
      wr(OFS_CHAN_MODE, sc1);
      rdreg(OFS_TRIG_CMP);
      check("active", {31'h0, rd[7]}, 32'h1);
      wait_done();
      @(posedge clk);
      check("irq", {31'h0, irq}, {31'h0, sc1[6]});
      check("chan", {27'h0, chan}, {27'h0, sc1[4:0]});
      if (smp > 0) check("sample_len", smp_cnt - smp0, smp);
      rdreg(OFS_RES_HIGH);
      check("res_high", rd, {30'h0, res[9:8]});
      rdreg(OFS_RES_LOW);
      check("res_low", rd, {24'h0, res[7:0]});
      rdreg(OFS_CHAN_MODE);
      check("flag_clear", rd, {24'h0, 1'b0, sc1[6:0]});
      rdreg(OFS_TRIG_CMP);
      check("idle", {31'h0, rd[7]}, 32'h0);
      check("irq_clear", {31'h0, irq}, 32'h0);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic s_reset();
      logic [7:0] ofs [9] = '{OFS_CONV_CFG, OFS_TRIG_CMP, OFS_CHAN_MODE, OFS_RES_HIGH,
                              OFS_RES_LOW, OFS_CMP_HIGH, OFS_CMP_LOW, OFS_PIN_FIRST,
                              OFS_PIN_SECOND};
      logic       e;
      foreach (ofs[k]) begin
         rdreg(ofs[k]);
         check("reset_value", rd, 32'h0);
      end
      apb(1'b0, 8'h24, 8'h00, rd, e);
      check("unmapped_err", {31'h0, e}, 32'h1);
      check("unmapped_data", rd, 32'h0);
   endtask

   task automatic s_regs();
      wr(OFS_CONV_CFG, 8'h98);
      wr(OFS_TRIG_CMP, 8'h3c);
      rdreg(OFS_CONV_CFG);
      check("cfg", rd, 32'h98);
      check("low_power", {31'h0, low_power}, 32'h1);
      rdreg(OFS_TRIG_CMP);
      check("trig", rd, 32'h30);
      wr(OFS_PIN_FIRST, 8'h02);
      wr(OFS_PIN_SECOND, 8'h81);
      rdreg(OFS_PIN_SECOND);
      check("pin_second", rd, 32'h81);
      check("pin_dis", {16'h0, pin_dis}, 32'h8102);
      wr(OFS_PIN_SECOND, 8'h00);
      wr(OFS_TRIG_CMP, 8'h00);
   endtask

   task automatic s_single();
      logic [7:0]  cfg [4] = '{8'h00, 8'h29, 8'h0a, 8'h05};
      logic [10:0] lvl [4] = '{11'h7ff, 11'h000, 11'h2a5, 11'h2a5};
      logic [9:0]  res [4] = '{10'h0ff, 10'h000, 10'h2a5, 10'h0a9};
      convert(8'h43, 11'h2a5, 10'h2a5, 24);
      wr(OFS_CONV_CFG, 8'h08);
      convert(8'h01, 11'h7ff, 10'h3ff, 4);
      foreach (cfg[k]) begin
         bits10 <= (cfg[k][3:2] == MODE_10BIT);
         wr(OFS_CONV_CFG, cfg[k]);
         convert(8'h01, lvl[k], res[k], 0);
      end
   endtask

   task automatic s_compare();
      bits10 <= 1'b1;
      wr(OFS_CONV_CFG, 8'h08);
      wr(OFS_CMP_HIGH, 8'h02);
      wr(OFS_CMP_LOW, 8'h00);
      rdreg(OFS_CMP_HIGH);
      check("cmp_high", rd, 32'h2);
      wr(OFS_TRIG_CMP, 8'h30);
      convert(8'h01, 11'h280, 10'h080, 0);
      level <= 11'h100;
      wr(OFS_CHAN_MODE, 8'h01);
      repeat (400) @(posedge clk);
      rdreg(OFS_CHAN_MODE);
      check("cmp_false_flag", rd, 32'h01);
      rdreg(OFS_RES_LOW);
      check("cmp_false_res", rd, 32'h80);
      wr(OFS_TRIG_CMP, 8'h20);
      convert(8'h01, 11'h080, 10'h280, 0);
      wr(OFS_TRIG_CMP, 8'h00);
   endtask

   task automatic s_lock();
      level <= 11'h155;
      wr(OFS_CHAN_MODE, 8'h21);
      wait_done();
      rdreg(OFS_RES_HIGH);
      check("lock_high", rd, 32'h01);
      level <= 11'h0aa;
      repeat (300) @(posedge clk);
      rdreg(OFS_RES_LOW);
      check("lock_low", rd, 32'h55);
      wait_done();
      rdreg(OFS_RES_HIGH);
      check("cont_high", rd, 32'h00);
      rdreg(OFS_RES_LOW);
      check("cont_low", rd, 32'haa);
      wait_done();
      wr(OFS_CHAN_MODE, 8'h01);
      rdreg(OFS_CHAN_MODE);
      check("abort_flag", rd, 32'h01);
      wait_done();
      rdreg(OFS_RES_LOW);
      check("abort_res", rd, 32'haa);
   endtask

   task automatic s_hwtrig();
      wr(OFS_TRIG_CMP, 8'h40);
      level <= 11'h3c3;
      wr(OFS_CHAN_MODE, 8'h01);
      repeat (200) @(posedge clk);
      rdreg(OFS_TRIG_CMP);
      check("hw_wait", rd, 32'h40);
      hw_trig <= 1'b1;
      repeat (4) @(posedge clk);
      hw_trig <= 1'b0;
      wait_done();
      rdreg(OFS_RES_LOW);
      check("hw_res", rd, 32'hc3);
      wr(OFS_TRIG_CMP, 8'h00);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      s_reset();
      s_regs();
      s_single();
      s_compare();
      s_lock();
      s_hwtrig();
      tally_and_finish();
   end
endmodule
